// ---- rtl/adc_sample_map.vh ----
// Purpose: shared constants for the sampling converter output pipeline
// Assumes: included by bare name from every design file that needs it
// Notes:   input levels are in units of one output step
`ifndef ADC_SAMPLE_MAP_VH
`define ADC_SAMPLE_MAP_VH

// result word layout
`define ADC_WORD_W        10
`define ADC_RESULT_MSB    9
`define ADC_RESULT_LSB    0

// pipeline depth in strobe periods
`define ADC_LATENCY       5

// width of the digitised front-end level
`define ADC_LEVEL_W       12

// nominal window: lowest level mapped to code zero, highest to all ones
`define ADC_LEVEL_LOW     12'h200
`define ADC_LEVEL_HIGH    12'h5FF

// codes
`define ADC_CODE_MAX      10'h3FF
`define ADC_CODE_MIN      10'h000
`define ADC_CODE_MID      10'h1FF

// reset values
`define ADC_WORD_RESET    10'h000
`define ADC_RANGE_RESET   1'h0
`define ADC_LEVEL_RESET   12'h000

`endif

// ---- rtl/adc_pipe_delay.v ----
// Purpose: strobe-advanced delay line for conversion results
// Assumes: shift_en is a one-cycle pulse in the core_clk domain
// Notes:   every stage moves together, so the line never bubbles
`timescale 1ns/1ps

module adc_pipe_delay #(
    parameter WIDTH = 11,
    parameter DEPTH = 4
) (
    input  wire             core_clk,
    input  wire             arst_n,
    input  wire             shift_en,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] stage_reg [0:DEPTH-1];

    ////////////////////////////////////////////////////////////////////////
    // first stage takes the new word on each strobe
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_reg[0] <= {WIDTH{1'b0}};
        end else if (shift_en) begin
            stage_reg[0] <= din;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // remaining stages shift one place per strobe
    genvar g;
    generate
        for (g = 1; g < DEPTH; g = g + 1) begin : g_stage
            always @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    stage_reg[g] <= {WIDTH{1'b0}};
                end else if (shift_en) begin
                    stage_reg[g] <= stage_reg[g-1];
                end
            end
        end
    endgenerate

    assign dout = stage_reg[DEPTH-1];

endmodule

// ---- rtl/adc_sample_output.v ----
// Purpose: digital side of a 10-bit pipelined sampling converter
// Assumes: sample strobe and front-end level arrive from outside core_clk
// Notes:   strobe high and low must each last at least two core_clk cycles
`timescale 1ns/1ps
`include "adc_sample_map.vh"

module adc_sample_output #(
    parameter WORD_W  = `ADC_WORD_W,
    parameter LEVEL_W = `ADC_LEVEL_W,
    parameter LATENCY = `ADC_LATENCY
) (
    input  wire               core_clk,
    input  wire               arst_n,
    input  wire               sample_strobe,
    input  wire [LEVEL_W-1:0] input_level,
    output reg  [WORD_W-1:0]  result_word,
    output reg                out_of_range,
    output reg                hold_active,
    output reg                result_valid
);

    ////////////////////////////////////////////////////////////////////////
    // local widths and decode helpers

    localparam PIPE_W  = WORD_W + 1;
    localparam DEPTH   = LATENCY - 1;
    localparam FILL_W  = 3;
    // the first strobe only flushes the reset level through, so real data needs one more
    localparam FILL_TOP = LATENCY + 1;
    localparam [FILL_W-1:0] FILL_FULL = FILL_TOP[FILL_W-1:0];

    // level above the nominal window, decode shared by flag and clamp
    function above_window;
        input [LEVEL_W-1:0] level;
        begin
            above_window = (level > `ADC_LEVEL_HIGH);
        end
    endfunction

    // level below the nominal window
    function below_window;
        input [LEVEL_W-1:0] level;
        begin
            below_window = (level < `ADC_LEVEL_LOW);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // synchronisers for the pins

    reg               strobe_meta_reg;
    reg               strobe_sync_reg;
    reg               strobe_prev_reg;
    reg [LEVEL_W-1:0] level_meta_reg;
    reg [LEVEL_W-1:0] level_sync_reg;

    // two flops before anything looks at a pin
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            strobe_meta_reg <= 1'b0;
            strobe_sync_reg <= 1'b0;
            strobe_prev_reg <= 1'b0;
            level_meta_reg  <= `ADC_LEVEL_RESET;
            level_sync_reg  <= `ADC_LEVEL_RESET;
        end else begin
            strobe_meta_reg <= sample_strobe;
            strobe_sync_reg <= strobe_meta_reg;
            strobe_prev_reg <= strobe_sync_reg;
            level_meta_reg  <= input_level;
            level_sync_reg  <= level_meta_reg;
        end
    end

    // rising edge seen only on synchronised copies
    wire strobe_rise = strobe_sync_reg & ~strobe_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // track and hold

    reg  [LEVEL_W-1:0] held_level_reg;
    reg  [LEVEL_W-1:0] held_level_next;

    // held level keeps its value between strobes and takes the synchronised level on the strobe edge
    always @* begin
        held_level_next = held_level_reg;
        if (strobe_rise) begin
            held_level_next = level_sync_reg;
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            held_level_reg <= `ADC_LEVEL_RESET;
        end else begin
            held_level_reg <= held_level_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion of the held level

    reg  [WORD_W-1:0]  code_conv;
    reg                range_conv;
    reg  [LEVEL_W-1:0] offset_level;

    // clamp outside the window so no invalid code can ever leave
    always @* begin
        offset_level = held_level_reg - `ADC_LEVEL_LOW;
        if (above_window(held_level_reg)) begin
            code_conv  = `ADC_CODE_MAX;
            range_conv = 1'b1;
        end else if (below_window(held_level_reg)) begin
            code_conv  = `ADC_CODE_MIN;
            range_conv = 1'b1;
        end else begin
            code_conv  = offset_level[WORD_W-1:0];
            range_conv = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion pipeline

    // the output latch counts as the last of the five delays
    reg                convert_pending_reg;
    wire [PIPE_W-1:0]  pipe_in;
    wire [PIPE_W-1:0]  pipe_out;

    // word and flag travel side by side so they stay paired
    assign pipe_in = {range_conv, code_conv};

    // conversion of the held level enters the line on the next strobe
    adc_pipe_delay #(
        .WIDTH    (PIPE_W),
        .DEPTH    (DEPTH)
    ) u_pipe (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .shift_en (strobe_rise),
        .din      (pipe_in),
        .dout     (pipe_out)
    );

    // marks that a frozen sample is being converted
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            convert_pending_reg <= 1'b0;
        end else if (strobe_rise) begin
            convert_pending_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fill tracking

    reg [FILL_W-1:0] fill_reg;
    reg [FILL_W-1:0] fill_next;

    // counts strobes until the output latch shows the first real sample
    always @* begin
        fill_next = fill_reg;
        if (strobe_rise && (fill_reg != FILL_FULL)) begin
            fill_next = fill_reg + 3'h1;
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_reg <= 3'h0;
        end else begin
            fill_reg <= fill_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output latches

    // word, flag and valid move only on a strobe edge and hold in between
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_word  <= `ADC_WORD_RESET;
            out_of_range <= `ADC_RANGE_RESET;
            result_valid <= 1'b0;
        end else if (strobe_rise) begin
            result_word  <= pipe_out[WORD_W-1:0];
            out_of_range <= pipe_out[WORD_W];
            result_valid <= (fill_next == FILL_FULL);
        end
    end

    // hold indicator mirrors the synchronised strobe level once the first strobe edge has been handled
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_active <= 1'b0;
        end else begin
            hold_active <= strobe_sync_reg & convert_pending_reg;
        end
    end

endmodule

// ---- bench/adc_sample_output_properties.sv ----
// Purpose: port checks for the sampling converter output pipeline
// Assumes: strobe stays high and low at least two core_clk cycles
// Notes:   shadows the three-edge strobe sync to find each handling edge
`timescale 1ns/1ps
module adc_sample_output_properties (
    input wire        core_clk,
    input wire        arst_n,
    input wire        sample_strobe,
    input wire [11:0] input_level,
    input wire [9:0]  result_word,
    input wire        out_of_range,
    input wire        hold_active,
    input wire        result_valid
);
    logic [2:0]  sync_reg;
    logic [2:0]  fill_reg;
    logic [11:0] lvl_a_reg, lvl_b_reg, q0_reg, q1_reg, q2_reg, q3_reg, q4_reg;
    wire         rise = sync_reg[1] & ~sync_reg[2];
    wire         full = fill_reg >= 3'h5;
    wire         over = q4_reg >= 12'h600;
    wire         under = q4_reg < 12'h200;
    wire  [11:0] span = q4_reg - 12'h200;
    wire  [9:0]  exp_word = over ? 10'h3FF : (under ? 10'h000 : span[9:0]);
    wire         exp_flag = over | under;
    wire         exp_msb = span[9];
    ////////////////////////////////////////////////////////////////////////
    // held levels kept here, since the word trails its sample by five strobes
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {sync_reg, fill_reg} <= 6'h00;
        end else begin
            sync_reg <= {sync_reg[1:0], sample_strobe};
            lvl_a_reg <= input_level;
            lvl_b_reg <= lvl_a_reg;
            if (rise) begin
                {q4_reg, q3_reg, q2_reg, q1_reg, q0_reg} <= {q3_reg, q2_reg, q1_reg, q0_reg, lvl_b_reg};
                fill_reg <= fill_reg + {2'h0, ~full};
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_still_between_strobes: assert property (!rise |=> $stable({result_word, out_of_range, result_valid}))
        else $error("output moved without a strobe");
    a_word_latency: assert property (rise && full |=> result_word == $past(exp_word))
        else $error("word not from the sample five strobes back");
    a_fill_reset_content: assert property (rise && fill_reg < 3'h4 |=>
        {result_valid, out_of_range, result_word} == 12'h000)
        else $error("fill phase showed data");
    a_flush_slot: assert property (rise && fill_reg == 3'h4 |=>
        {result_valid, out_of_range, result_word} == 12'h400)
        else $error("fifth update not the flagged reset conversion");
    a_msb_weight: assert property (rise && full && !exp_flag |=> result_word[9] == $past(exp_msb))
        else $error("top bit of word has wrong weight");
    a_flag_latency: assert property (rise && full |=> out_of_range == $past(exp_flag))
        else $error("range flag wrong for its sample");
    a_high_all_ones: assert property (rise && full && over |=> result_word == 10'h3FF && out_of_range)
        else $error("high overdrive not all ones with flag");
    a_low_all_zeros: assert property (rise && full && under |=> result_word == 10'h000 && out_of_range)
        else $error("low overdrive not zero with flag");
    a_clamp_extreme: assert property (out_of_range |-> result_word == 10'h3FF || result_word == 10'h000)
        else $error("flagged word is not an extreme code");
    a_valid_latched: assert property (rise && full |=> result_valid [*3])
        else $error("valid dropped after fill");
    a_hold_follows: assert property (rise && fill_reg != 3'h0 |=> ##1 hold_active)
        else $error("hold not entered after strobe");
endmodule
bind adc_sample_output adc_sample_output_properties chk (.core_clk, .arst_n, .sample_strobe, .input_level,
    .result_word, .out_of_range, .hold_active, .result_valid);

// ---- bench/capture_side_model.sv ----
// Purpose: capture logic that makes the strobe and latches results
// Assumes: strobe period at least five core_clk cycles
// Notes:   latches one cycle after the handling edge so the word has settled
`timescale 1ns/1ps
module capture_side_model (
    input  logic       core_clk,
    output logic       sample_strobe,
    input  logic [9:0] result_word,
    input  logic       out_of_range,
    input  logic       result_valid
);
    logic [11:0] cap_reg;
    event        captured;
    initial sample_strobe = 1'b0;
    // one strobe period, h cycles high then l low
    task automatic pulse(input int h, input int l);
        @(posedge core_clk);
        sample_strobe <= 1'b1;
        repeat (h) @(posedge core_clk);
        sample_strobe <= 1'b0;
        repeat (l) @(posedge core_clk);
    endtask
    // word, flag and valid taken together, never torn apart
    always @(posedge sample_strobe) begin
        repeat (4) @(posedge core_clk);
        #1 cap_reg = {result_valid, out_of_range, result_word};
        -> captured;
    end
endmodule

// ---- bench/pipelined_adc_sample_output_bench.sv ----
// Purpose: self-checking bench for the converter output pipeline
// Assumes: expected {valid, flag, word} queued per strobe, five fill entries first
// Notes:   last five samples stay queued, the run stops before they surface
`timescale 1ns/1ps
module pipelined_adc_sample_output_bench;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [11:0] input_level = 12'h000;
    logic        sample_strobe, out_of_range, hold_active, result_valid;
    logic [9:0]  result_word;
    // four reset words, then the flagged conversion of the reset level, not yet valid
    logic [11:0] exp_q[$] = '{12'h000, 12'h000, 12'h000, 12'h000, 12'h400};
    logic [11:0] edges[8] = '{12'h1FF, 12'h200, 12'h5FF, 12'h600, 12'h3FF, 12'h000, 12'hFFF, 12'h4FF};
    logic [11:0] lv, want;
    int          err_count = 0;
    int          checks = 0;
    int          seed = 32'hd39edbf4;
    adc_sample_output DUT (.core_clk, .arst_n, .sample_strobe, .input_level, .result_word, .out_of_range,
        .hold_active, .result_valid);
    capture_side_model cap (.core_clk, .sample_strobe, .result_word, .out_of_range, .result_valid);
    ////////////////////////////////////////////////////////////////////////
    // expected capture for one level: valid, flag, clamped word
    function automatic logic [11:0] coded(input logic [11:0] l);
        logic [11:0] d;
        d = l - 12'h200;
        if (l >= 12'h600) return 12'hFFF;
        if (l < 12'h200) return 12'hC00;
        return {2'b10, d[9:0]};
    endfunction
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial forever #25 core_clk = ~core_clk;
    // window edges and back-to-back overdrive first, then random levels
    initial begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            lv = (i < 8) ? edges[i] : 12'($random(seed));
            @(posedge core_clk);
            input_level <= lv;
            exp_q.push_back(coded(lv));
            cap.pulse(2 + ($random(seed) & 1), 2 + ($random(seed) & 3));
        end
        repeat (10) @(posedge core_clk);
        complete_run;
    end
    // oldest note against each capture
    always @(cap.captured) begin
        want = exp_q.pop_front();
        checks++;
        if (cap.cap_reg !== want) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, cap.cap_reg, want);
        end
    end
    // hang guard, well past the longest strobe sequence
    initial begin
        #200000;
        err_count++;
        complete_run;
    end
endmodule
